// *** bench/alx_exec_sva.sv ***
// Checker for the execution datapath ports.
// Assumes one clock; requests only after the reset release settles.
`timescale 1ns/1ps
`default_nettype none
module alx_exec_sva (
   input wire logic sys_clk, rst_b, exec_vld, bit_clear_file, ptr_sel, dest_sel,
   input wire logic [2:0] exec_op, bit_idx,
   input wire logic [7:0] literal, file_rdata, acc_ff, file_wdata_ff,
   input wire logic carry_ff, digit_carry_flag_ff, zero_ff, file_we_ff,
   input wire logic [15:0] indirect_pointer0_ff, indirect_pointer1_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire cl = exec_vld & ~bit_clear_file;
   wire [7:0] b = (exec_op == 3'h3) ? literal : file_rdata;
   wire ci = (exec_op == 3'h7) & carry_ff;
   wire [8:0] sum = acc_ff + b + ci;
   wire cy = sum[8];
   wire dc = (acc_ff[3:0] + b[3:0] + ci) > 5'h0F;
   wire [15:0] pv = ptr_sel ? indirect_pointer1_ff : indirect_pointer0_ff;
   wire [15:0] off = {{10{literal[5]}}, literal[5:0]};
   // Bit clear wins over the opcode field
   wire [7:0] res = bit_clear_file ? file_rdata & ~(8'h01 << bit_idx) :
      exec_op == 3'h2 ? acc_ff & literal : exec_op == 3'h4 ? acc_ff & file_rdata :
      exec_op == 3'h6 ? {file_rdata[7], file_rdata[7:1]} : sum[7:0];
   property p_ptr; cl && exec_op == 3'h1 |=> ($past(ptr_sel) ? indirect_pointer1_ff :
      indirect_pointer0_ff) == $past(pv) + $past(off) && $stable(zero_ff); endproperty
   a_ptr: assert property (p_ptr) else $error("bad pointer");
   property p_acc; cl && (exec_op[2] && !dest_sel || exec_op[2:1] == 2'h1)
      |=> acc_ff == $past(res); endproperty
   a_acc: assert property (p_acc) else $error("bad acc");
   property p_wb; exec_vld && (bit_clear_file || exec_op[2] && dest_sel) |=> file_we_ff
      && file_wdata_ff == $past(res) && $stable(acc_ff); endproperty
   a_wb: assert property (p_wb) else $error("bad write");
   property p_zero; cl && exec_op > 3'h1 |=> zero_ff == ($past(res) == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("bad zero");
   property p_add; cl && exec_op[0] && exec_op != 3'h1 |=> carry_ff == $past(cy)
      && digit_carry_flag_ff == $past(dc); endproperty
   a_add: assert property (p_add) else $error("bad carry");
   property p_and; cl && (exec_op == 3'h2 || exec_op == 3'h4) |=> $stable(carry_ff)
      && $stable(digit_carry_flag_ff); endproperty
   a_and: assert property (p_and) else $error("and flags");
   property p_asr; cl && exec_op == 3'h6 |=> {7'h00, carry_ff} ==
      ($past(file_rdata) & 8'h01); endproperty
   a_asr: assert property (p_asr) else $error("bad shift");
   property p_bcf; exec_vld && bit_clear_file |=> $stable(carry_ff) && $stable(zero_ff)
      && $stable(digit_carry_flag_ff); endproperty
   a_bcf: assert property (p_bcf) else $error("clear flags");
   c_ptr: cover property (cl && exec_op == 3'h1);
   c_wb: cover property (file_we_ff);
   c_bcf: cover property (exec_vld && bit_clear_file);
endmodule
bind alx_exec alx_exec_sva alx_exec_sva_inst (.sys_clk, .rst_b, .exec_vld, .bit_clear_file,
   .ptr_sel, .dest_sel, .exec_op, .bit_idx, .literal, .file_rdata, .acc_ff, .file_wdata_ff,
   .carry_ff, .digit_carry_flag_ff, .zero_ff, .file_we_ff, .indirect_pointer0_ff,
   .indirect_pointer1_ff);
`default_nettype wire

// *** bench/arith_logic_instr_exec_bench.sv ***
// Self-checking bench for the execution datapath.
// Assumes the checker is bound in; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module arith_logic_instr_exec_bench;
   logic sys_clk = 1'h0, rst_b = 1'h0, exec_vld = 1'h0, bit_clear_file, ptr_sel, dest_sel;
   logic [2:0] exec_op, bit_idx;
   logic [7:0] literal, file_rdata, acc_ff, file_wdata_ff;
   logic carry_ff, digit_carry_flag_ff, zero_ff, file_we_ff;
   logic [15:0] indirect_pointer0_ff, indirect_pointer1_ff;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   wire [10:0] st = {acc_ff, carry_ff, digit_carry_flag_ff, zero_ff};
   wire [8:0] wb = {file_we_ff, file_wdata_ff};
   alx_exec alx_exec_inst (.sys_clk, .rst_b, .exec_vld, .exec_op, .bit_clear_file, .literal,
      .ptr_sel, .dest_sel, .bit_idx, .file_rdata, .acc_ff, .carry_ff, .digit_carry_flag_ff,
      .zero_ff, .indirect_pointer0_ff, .indirect_pointer1_ff, .file_we_ff, .file_wdata_ff);
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Ceiling far above the ~60 cycles the run needs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic summarize();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   // Code is clear, pointer, dest, op; bit index rides in the literal
   task automatic ex(input logic [5:0] c, input logic [7:0] l, input logic [7:0] f);
      @(negedge sys_clk);
      {bit_clear_file, ptr_sel, dest_sel, exec_op} = c;
      {literal, bit_idx, file_rdata, exec_vld} = {l, l[2:0], f, 1'h1};
      @(negedge sys_clk);
      exec_vld = 1'h0;
   endtask
   task automatic t_ptr();
      ex(6'h01, 8'hE0, 8'h00);
      chk("ptr0", 16'hFFE0, indirect_pointer0_ff);
      ex(6'h01, 8'h1F, 8'h00);
      chk("ptr0", 16'hFFFF, indirect_pointer0_ff);
      ex(6'h01, 8'h41, 8'h00);
      chk("ptr0", 16'h0000, indirect_pointer0_ff);
      ex(6'h11, 8'h1F, 8'h00);
      chk("ptr1", 16'h001F, indirect_pointer1_ff);
      chk("st", 16'h0000, st);
   endtask
   task automatic t_lit();
      ex(6'h03, 8'hFF, 8'h00);
      chk("st", 16'h07F8, st);
      ex(6'h03, 8'h01, 8'h00);
      chk("st", 16'h0007, st);
      ex(6'h02, 8'hFF, 8'h00);
      chk("st", 16'h0007, st);
      ex(6'h03, 8'h3C, 8'h00);
      ex(6'h02, 8'h0F, 8'h00);
      chk("st", 16'h0060, st);
   endtask
   task automatic t_file();
      ex(6'h0D, 8'h00, 8'hF8);
      chk("st", 16'h0066, st);
      chk("wb", 16'h0104, wb);
      ex(6'h07, 8'h00, 8'h00);
      chk("st", 16'h0068, st);
      ex(6'h0C, 8'h00, 8'h03);
      chk("wb", 16'h0101, wb);
      ex(6'h06, 8'h00, 8'h81);
      chk("st", 16'h0604, st);
      ex(6'h0E, 8'h00, 8'h01);
      chk("wb", 16'h0100, wb);
      chk("st", 16'h0605, st);
      ex(6'h0F, 8'h00, 8'h40);
      chk("wb", 16'h0101, wb);
      chk("st", 16'h0604, st);
      for (int i = 0; i < 8; i++) begin
         ex(6'h20, i[7:0], 8'hFF);
         chk("wb", {7'h00, 1'h1, 8'hFF & ~(8'h01 << i)}, wb);
      end
      chk("st", 16'h0604, st);
      ex(6'h00, 8'hFF, 8'hFF);
      chk("wb", 16'h007F, wb);
      chk("st", 16'h0604, st);
   endtask
   initial begin
      {bit_clear_file, ptr_sel, dest_sel, exec_op, literal, bit_idx, file_rdata} = 25'h0;
      repeat (8) @(negedge sys_clk);
      rst_b = 1'h1;
      repeat (3) @(negedge sys_clk);
      t_ptr();
      t_lit();
      t_file();
      summarize();
   end
endmodule
`default_nettype wire

// *** verilog/alx_bit_clear.v ***
// Bit-clear helper: result with one selected bit forced low.
// Assumes index and data are stable in the same cycle as the request.
`timescale 1ns/1ps
`default_nettype none
module alx_bit_clear (
   // Operand
   input wire [7:0] din,
   input wire [2:0] bit_sel,
   // Result
   output wire [7:0] dout
);
   assign dout = din & ~(8'h01 << bit_sel); // see RULE11
endmodule
`default_nettype wire

// *** verilog/alx_exec.v ***
// Execution datapath: accumulator, flags, two indirect pointers, file results.
// Assumes the file operand is presented combinationally with the request.
`timescale 1ns/1ps
`default_nettype none
`include "alx_map.vh"
module alx_exec (
   // Clock and reset
   input wire sys_clk,
   input wire rst_b,
   // Request
   input wire exec_vld,
   input wire [2:0] exec_op,
   input wire bit_clear_file,
   input wire [7:0] literal,
   input wire ptr_sel,
   input wire dest_sel,
   input wire [2:0] bit_idx,
   input wire [7:0] file_rdata,
   // State
   output reg [7:0] acc_ff,
   output reg carry_ff,
   output reg digit_carry_flag_ff,
   output reg zero_ff,
   output reg [15:0] indirect_pointer0_ff,
   output reg [15:0] indirect_pointer1_ff,
   // File write-back
   output reg file_we_ff,
   output reg [7:0] file_wdata_ff
);
   reg rst_meta_ff;
   reg rst_sync_ff;
   wire rst_int_b = rst_sync_ff;
   wire [7:0] clr_val;
   reg [7:0] res;
   reg [9:0] sum;
   reg upd_c;
   reg upd_dc;
   reg upd_z;
   reg to_file;
   reg [15:0] ptr_sum;
   reg [8:0] nib;

   // Sum with carry in; bit 8 is carry, bit 9 the nibble carry
   function [9:0] add8;
      input [7:0] a;
      input [7:0] b;
      input cin;
      reg [4:0] lo;
      reg [8:0] full;
      begin
         lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         add8 = {lo[4], full};
      end
   endfunction

   // Reset released through two flops to avoid removal hazards
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   alx_bit_clear u_bit_clear (
      .din(file_rdata),
      .bit_sel(bit_idx),
      .dout(clr_val)
   );

   always @* begin
      res = 8'h00;
      sum = 10'h000;
      nib = 9'h000;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      to_file = 1'b0;
      ptr_sum = ptr_sel ? indirect_pointer1_ff : indirect_pointer0_ff;
      if (bit_clear_file) begin
         res = clr_val; // see RULE11
         to_file = 1'b1;
      end else begin
         case (exec_op)
            `ALX_OP_ADD_PTR: begin
               // Sign extension of the 6-bit literal; see RULE1
               ptr_sum = ptr_sum + {{10{literal[`ALX_LIT_SIGN]}}, literal[5:0]}; // see RULE2
            end
            `ALX_OP_AND_LIT: begin
               res = acc_ff & literal; // see RULE3
               upd_z = 1'b1;
            end
            `ALX_OP_ADD_LIT: begin
               sum = add8(acc_ff, literal, 1'b0); // see RULE4
               res = sum[7:0];
               {upd_c, upd_dc, upd_z} = 3'h7;
            end
            `ALX_OP_AND_FILE: begin
               res = acc_ff & file_rdata; // see RULE5
               upd_z = 1'b1;
               to_file = dest_sel; // see RULE7
            end
            `ALX_OP_ADD_FILE: begin
               sum = add8(acc_ff, file_rdata, 1'b0); // see RULE6
               res = sum[7:0];
               {upd_c, upd_dc, upd_z} = 3'h7;
               to_file = dest_sel; // see RULE7
            end
            `ALX_OP_ASR_FILE: begin
               res = {file_rdata[7], file_rdata[7:1]}; // see RULE8 see RULE9
               sum = {1'b0, file_rdata[0], 8'h00}; // see RULE8
               upd_c = 1'b1;
               upd_z = 1'b1;
               to_file = dest_sel; // see RULE7
            end
            `ALX_OP_ADDC_FILE: begin
               sum = add8(acc_ff, file_rdata, carry_ff); // see RULE10
               res = sum[7:0];
               {upd_c, upd_dc, upd_z} = 3'h7;
               to_file = dest_sel; // see RULE7
            end
            default: begin
               res = 8'h00;
            end
         endcase
      end
      nib = {8'h00, sum[9]};
   end

   always @(posedge sys_clk or negedge rst_int_b) begin
      if (!rst_int_b) begin
         acc_ff <= `ALX_RST_ACC;
         carry_ff <= 1'b0;
         digit_carry_flag_ff <= 1'b0;
         zero_ff <= 1'b0;
         indirect_pointer0_ff <= `ALX_RST_PTR;
         indirect_pointer1_ff <= `ALX_RST_PTR;
         file_we_ff <= 1'b0;
         file_wdata_ff <= 8'h00;
      end else begin
         file_we_ff <= 1'b0;
         if (exec_vld) begin
            // Pointer add never touches flags; see RULE1
            if (!bit_clear_file && exec_op == `ALX_OP_ADD_PTR) begin
               if (ptr_sel)
                  indirect_pointer1_ff <= ptr_sum;
               else
                  indirect_pointer0_ff <= ptr_sum;
            end else if (bit_clear_file || exec_op != `ALX_OP_NOP) begin
               if (to_file) begin
                  file_we_ff <= 1'b1;
                  file_wdata_ff <= res;
               end else begin
                  acc_ff <= res;
               end
            end
            if (upd_c)
               carry_ff <= sum[8];
            if (upd_dc)
               digit_carry_flag_ff <= nib[0]; // see RULE12
            if (upd_z)
               zero_ff <= (res == 8'h00); // see RULE12
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/alx_map.vh ***
// Constants for the arithmetic/logic execution datapath.
// Assumes a single core clock; included by the datapath files only.
// Overview of operation
// RULE1: Add-to-pointer sign-extends a 6-bit literal (-32..31) and adds it to pointer 0 or 1, flags untouched.
// RULE2: Pointer sums wrap modulo 65536, keeping the low sixteen bits.
// RULE3: AND-literal puts accumulator AND literal into the accumulator and updates only zero.
// RULE4: Add-literal puts accumulator plus literal into the accumulator and updates carry, digit carry and zero.
// RULE5: AND-with-file ANDs the accumulator with the file register and updates only zero.
// RULE6: Add-with-file sums accumulator and file register and updates carry, digit carry and zero.
// RULE7: Destination bit zero sends a file-form result to the accumulator, one writes it back to the file register.
// RULE8: Arithmetic shift right moves each file bit one place down, old bit 0 to carry, updating carry and zero.
// RULE9: Arithmetic shift right keeps the original top bit as the result's top bit.
// RULE10: Add-with-carry sums accumulator, file byte and carry, routes by destination, updates carry, digit carry, zero.
// RULE11: Bit-clear zeroes the bit picked by a 3-bit index in the file register, leaving other bits and flags alone.
// RULE12: Digit carry is the carry from bit 3 into bit 4 and zero is set exactly when the 8-bit result is zero.
`ifndef ALX_MAP_VH
`define ALX_MAP_VH
`define ALX_OP_NOP 3'h0
`define ALX_OP_ADD_PTR 3'h1
`define ALX_OP_AND_LIT 3'h2
`define ALX_OP_ADD_LIT 3'h3
`define ALX_OP_AND_FILE 3'h4
`define ALX_OP_ADD_FILE 3'h5
`define ALX_OP_ASR_FILE 3'h6
`define ALX_OP_ADDC_FILE 3'h7
`define ALX_RST_ACC 8'h00
`define ALX_RST_PTR 16'h0000
`define ALX_LIT_SIGN 5
`endif
